// >>> hdl/fcw_flash_ctrl.sv
// Module: host controller driving the flash command bus from APB
`timescale 1ns/10ps
// Contract
// (RULE_01) Device latches address late falling edge, data early rising edge.
// (RULE_02) Sector address bits A20..A12 pick one sector.
// (RULE_03) Host writes all command cycles; reads only array and autoselect 4th.
// (RULE_04) Upper data byte ignored in command cycles except read/program data.
// (RULE_05) Address bits A20..A11 are don't care in command cycles.
// (RULE_06) Array-read bank returns data with no unlock cycles.
// (RULE_07) Host resets to leave autoselect or after timing-limit bit rises.
// (RULE_08) Protect verify reads 00h unprotected, 01h protected.
// (RULE_09) Bypass program only after bypass entry; bypass reset leaves it.
// (RULE_10) Erase suspend honoured only during sector erase, with bank address.
// (RULE_11) Erase resume acts only while suspended, otherwise ignored.
// (RULE_12) Query accepted only in array read or autoselect.
// (RULE_13) Reset ends temporary unprotect, except while erase is suspended.
// (RULE_14) Program polling bit reads complement until done; read at program address.
// (RULE_15) Protected program shows busy status about 1 us then array read.
// (RULE_16) Erase polling bit reads 0 then 1; read inside erased sector.
// (RULE_17) All-protected erase shows busy about 100 us; else skips protected.
// (RULE_18) Polling bit may settle early; take data on a later read.
// (RULE_19) Status valid from final write strobe rising edge.
// (RULE_20) Ready/busy pin low while programming or erasing.
// (RULE_21) Toggle bit inverts on each read while busy; stops when done.
// (RULE_22) Toggle bit stops on suspend, toggles during suspend program.
// (RULE_23) Timing-limit bit rises when an operation fails.
// (RULE_24) Second toggle bit inverts on reads in erase-selected sectors.
// (RULE_25) Erase-timer bit 0 during window, 1 once erase begins.
// (RULE_26) Host reads status at the busy bank's address.
// (RULE_27) Mismatched write aborts a partial sequence to array read.
module fcw_flash_ctrl import fcw_pkg::*; #(
  parameter int AW = 21,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash bus
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [AW-1:0] flashAddr,
  input wire logic [DW-1:0] flashDqIn,
  output logic [DW-1:0] flashDqOut,
  output logic flashDqOeN,
  input wire logic ready_busy_n
);
  // ==========================================================
  // Sequencer state
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_STROBE = 3'b010,
    S_RECOVER = 3'b011,
    S_NEXT = 3'b100
  } fcw_state_t;

  typedef enum logic [1:0] {
    P_NONE = 2'b00,
    P_POLL = 2'b01,
    P_FINAL = 2'b10
  } fcw_phase_t;

  fcw_state_t state_q, state_d;
  fcw_phase_t phase_q, phase_d;
  fcw_op_t op_q, op_d;
  logic [2:0] step_q, step_d;
  logic [3:0] cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d, prev_q, prev_d;
  logic bypass_q, bypass_d, fail_q, fail_d, done_q, done_d;
  logic limitSeen_q, limitSeen_d, first_q, first_d;
  logic ceN_q, ceN_d, oeN_q, oeN_d, weN_q, weN_d, dqOeN_q, dqOeN_d;
  logic [AW-1:0] fAddr_q, fAddr_d;
  logic [DW-1:0] fDq_q, fDq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;

  // One bus step: {isRead, last, address, data}
  logic stRead, stLast;
  logic [AW-1:0] stAddr;
  logic [DW-1:0] stData;
  logic apbWr, apbSetup, start;

  assign apbSetup = psel & ~penable & ~pready_q;
  assign apbWr = psel & penable & pready_q & pwrite;
  assign start = apbWr && paddr == REG_CTRL && state_q == S_IDLE;

  // Step table: command cycles per operation
  always_comb begin
    logic [AW-1:0] u1, u2;
    u1 = {addr_q[AW-1:11], ADR_UNLOCK1}; // RULE_05
    u2 = {addr_q[AW-1:11], ADR_UNLOCK2};
    stRead = 1'b0;
    stLast = 1'b1;
    stAddr = u1;
    stData = {8'h00, CMD_RESET}; // RULE_04
    if (phase_q != P_NONE) begin
      stRead = 1'b1; // RULE_26
      stAddr = addr_q;
    end else begin
      case (op_q)
        OP_READ: begin
          stRead = 1'b1; // RULE_03 RULE_06
          stAddr = addr_q;
        end
        OP_PROGRAM: begin
          if (bypass_q) begin // RULE_09
            stLast = step_q == 3'd1;
            stData[7:0] = CMD_PROGRAM;
            if (step_q == 3'd1) begin
              stAddr = addr_q;
              stData = wdata_q;
            end
          end else begin
            stLast = step_q == 3'd3;
            case (step_q)
              3'd0: stData[7:0] = CMD_UNLOCK1;
              3'd1: begin
                stAddr = u2;
                stData[7:0] = CMD_UNLOCK2;
              end
              3'd2: stData[7:0] = CMD_PROGRAM;
              default: begin
                stAddr = addr_q;
                stData = wdata_q;
              end
            endcase
          end
        end
        OP_CHIP_ERASE, OP_SECT_ERASE: begin
          stLast = step_q == 3'd5;
          case (step_q)
            3'd0, 3'd3: stData[7:0] = CMD_UNLOCK1;
            3'd1, 3'd4: begin
              stAddr = u2;
              stData[7:0] = CMD_UNLOCK2;
            end
            3'd2: stData[7:0] = CMD_ERASE;
            default: begin
              stData[7:0] = CMD_CHIP;
              if (op_q == OP_SECT_ERASE) begin
                stAddr = addr_q; // RULE_02
                stData[7:0] = CMD_SECTOR;
              end
            end
          endcase
        end
        OP_SUSPEND: begin
          stAddr = addr_q; // RULE_10
          stData[7:0] = CMD_SUSPEND;
        end
        OP_RESUME: stData[7:0] = CMD_RESUME; // RULE_11
        OP_QUERY: begin
          stAddr = {addr_q[AW-1:11], ADR_QUERY}; // RULE_12
          stData[7:0] = CMD_QUERY;
        end
        OP_BYP_EXIT: begin
          stLast = step_q == 3'd1;
          stData[7:0] = (step_q == 3'd0) ? CMD_AUTOSEL : CMD_BYP_EXIT2;
        end
        OP_PROT_VERIFY, OP_BYP_ENTER, OP_TEMP_UNPROT: begin
          stLast = step_q == 3'd3 || (op_q != OP_PROT_VERIFY && step_q == 3'd2);
          case (step_q)
            3'd0: stData[7:0] = CMD_UNLOCK1;
            3'd1: begin
              stAddr = u2;
              stData[7:0] = CMD_UNLOCK2;
            end
            3'd2: stData[7:0] = (op_q == OP_PROT_VERIFY) ? CMD_AUTOSEL :
              (op_q == OP_BYP_ENTER) ? CMD_BYPASS : CMD_TEMP_UNPROT;
            default: begin
              stRead = 1'b1; // RULE_03 RULE_08
              stAddr = {addr_q[AW-1:12], ADR_PROT_RD};
            end
          endcase
        end
        default: stData[7:0] = CMD_RESET; // RULE_07 RULE_13
      endcase
    end
  end

  // Next-state logic for the sequencer and flash pins
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    op_d = op_q;
    step_d = step_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    prev_d = prev_q;
    bypass_d = bypass_q;
    fail_d = fail_q;
    done_d = done_q;
    limitSeen_d = limitSeen_q;
    first_d = first_q;
    ceN_d = ceN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    dqOeN_d = dqOeN_q;
    fAddr_d = fAddr_q;
    fDq_d = fDq_q;
    if (apbWr && paddr == REG_ADDR && state_q == S_IDLE)
      addr_d = pwdata[AW-1:0];
    if (apbWr && paddr == REG_WDATA && state_q == S_IDLE)
      wdata_d = pwdata[DW-1:0];
    case (state_q)
      S_IDLE: begin
        if (start) begin
          op_d = fcw_op_t'(pwdata[3:0]);
          step_d = 3'd0;
          phase_d = P_NONE;
          fail_d = 1'b0;
          done_d = 1'b0;
          state_d = S_SETUP;
        end
      end
      S_SETUP: begin
        // Address stable before the strobe falls
        fAddr_d = stAddr; // RULE_01
        fDq_d = stData;
        dqOeN_d = stRead;
        ceN_d = 1'b0;
        cnt_d = 4'd0;
        state_d = S_STROBE;
      end
      S_STROBE: begin
        weN_d = stRead;
        oeN_d = ~stRead;
        cnt_d = cnt_q + 4'd1;
        if (cnt_q == 4'(stRead ? OE_CYC : WE_CYC)) begin
          // Data held until after the write strobe rises
          if (stRead)
            rdata_d = flashDqIn; // RULE_18
          weN_d = 1'b1;
          oeN_d = 1'b1;
          ceN_d = 1'b1;
          cnt_d = 4'd0;
          state_d = S_RECOVER;
        end
      end
      S_RECOVER: begin
        dqOeN_d = 1'b1;
        cnt_d = cnt_q + 4'd1;
        if (cnt_q == 4'(REC_CYC))
          state_d = S_NEXT;
      end
      S_NEXT: begin
        state_d = S_SETUP;
        if (phase_q == P_POLL) begin
          // Toggle-bit check, started only after final write strobe
          prev_d = rdata_q; // RULE_19
          first_d = 1'b0;
          if (!first_q && rdata_q[DQ_TOGGLE] == prev_q[DQ_TOGGLE]) begin
            phase_d = P_FINAL; // RULE_21 RULE_22
          end else if (!first_q && limitSeen_q) begin
            fail_d = 1'b1; // RULE_23
            phase_d = P_NONE;
            op_d = OP_RESET; // RULE_07
            step_d = 3'd0;
          end else if (rdata_q[DQ_LIMIT]) begin
            limitSeen_d = 1'b1;
          end
        end else if (phase_q == P_FINAL || stLast) begin
          if (phase_q == P_NONE && (op_q == OP_PROGRAM ||
              op_q == OP_CHIP_ERASE || op_q == OP_SECT_ERASE)) begin
            phase_d = P_POLL; // RULE_14 RULE_16 RULE_15 RULE_17
            first_d = 1'b1;
            limitSeen_d = 1'b0;
          end else begin
            if (op_q == OP_BYP_ENTER)
              bypass_d = 1'b1;
            if (op_q == OP_BYP_EXIT || op_q == OP_RESET)
              bypass_d = 1'b0; // RULE_09
            done_d = 1'b1;
            phase_d = P_NONE;
            state_d = S_IDLE;
          end
        end else begin
          step_d = step_q + 3'd1;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // APB answer: zero wait states, registered read data
  always_comb begin
    pready_d = apbSetup;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (apbSetup) begin
      case (paddr)
        REG_CTRL: prdata_d = {28'h000_0000, op_q};
        REG_ADDR: prdata_d = 32'(addr_q);
        REG_WDATA: prdata_d = 32'(wdata_q);
        REG_RDATA: prdata_d = 32'(rdata_q);
        REG_STATUS: begin
          prdata_d[ST_BUSY] = state_q != S_IDLE;
          prdata_d[ST_FAIL] = fail_q;
          prdata_d[ST_BYPASS] = bypass_q;
          prdata_d[ST_RDY] = ready_busy_n; // RULE_20
          prdata_d[ST_DONE] = done_q;
        end
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      phase_q <= P_NONE;
      op_q <= OP_READ;
      step_q <= 3'd0;
      cnt_q <= 4'h0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      prev_q <= '0;
      bypass_q <= 1'b0;
      fail_q <= 1'b0;
      done_q <= 1'b0;
      limitSeen_q <= 1'b0;
      first_q <= 1'b0;
      ceN_q <= 1'b1;
      oeN_q <= 1'b1;
      weN_q <= 1'b1;
      dqOeN_q <= 1'b1;
      fAddr_q <= '0;
      fDq_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      op_q <= op_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      prev_q <= prev_d;
      bypass_q <= bypass_d;
      fail_q <= fail_d;
      done_q <= done_d;
      limitSeen_q <= limitSeen_d;
      first_q <= first_d;
      ceN_q <= ceN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      dqOeN_q <= dqOeN_d;
      fAddr_q <= fAddr_d;
      fDq_q <= fDq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flashCeN = ceN_q;
  assign flashOeN = oeN_q;
  assign flashWeN = weN_q;
  assign flashAddr = fAddr_q;
  assign flashDqOut = fDq_q;
  assign flashDqOeN = dqOeN_q;
endmodule

// >>> hdl/fcw_pkg.sv
// Package: constants for the flash command and write-status controller
package fcw_pkg;
  // ==========================================================
  // Register map (APB byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_BYPASS = 2;
  localparam int ST_RDY = 3;
  localparam int ST_DONE = 4;
  // ==========================================================
  // Operation codes written to CTRL[3:0]
  typedef enum logic [3:0] {
    OP_READ = 4'b0000,
    OP_RESET = 4'b0001,
    OP_PROGRAM = 4'b0010,
    OP_CHIP_ERASE = 4'b0011,
    OP_SECT_ERASE = 4'b0100,
    OP_SUSPEND = 4'b0101,
    OP_RESUME = 4'b0110,
    OP_PROT_VERIFY = 4'b0111,
    OP_BYP_ENTER = 4'b1000,
    OP_BYP_EXIT = 4'b1001,
    OP_QUERY = 4'b1010,
    OP_TEMP_UNPROT = 4'b1011
  } fcw_op_t;
  // ==========================================================
  // Command bytes and unlock addresses (word mode, low address bits)
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_TEMP_UNPROT = 8'h77;
  localparam logic [10:0] ADR_UNLOCK1 = 11'h555;
  localparam logic [10:0] ADR_UNLOCK2 = 11'h2AA;
  localparam logic [10:0] ADR_QUERY = 11'h055;
  localparam logic [11:0] ADR_PROT_RD = 12'h002;
  // Status data bits
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_LIMIT = 5;
  // ==========================================================
  // Bus timing
  localparam int CLK_MHZ = 100;
  localparam int T_STROBE_NS = 35;
  localparam int T_ACCESS_NS = 70;
  localparam int T_RECOVER_NS = 20;
  localparam int WE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int OE_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
endpackage

// >>> testbench/fcw_flash_ctrl_assertions.sv
// Checker: flash bus strobe shapes and APB answer timing
`timescale 1ns/10ps
module fcw_flash_ctrl_assertions #(
  parameter int AW = 21,
  parameter int DW = 16
) (
  // Clock, reset and APB
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Flash bus
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic [AW-1:0] flashAddr,
  input wire logic [DW-1:0] flashDqOut,
  input wire logic flashDqOeN
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Strobe pulse pieces
  sequence s_weLow;
    !flashWeN [*4];
  endsequence
  sequence s_oeLow;
    !flashOeN [*7];
  endsequence
  sequence s_idle;
    flashWeN && flashOeN && flashCeN;
  endsequence
  // ==========================================================
  // Relations
  property p_weShape; $fell(flashWeN) |-> s_weLow ##1 s_idle; endproperty
  a_weShape: assert property (p_weShape)
    else $error("write pulse malformed");
  property p_oeShape; $fell(flashOeN) |-> s_oeLow ##1 s_idle; endproperty
  a_oeShape: assert property (p_oeShape)
    else $error("read pulse malformed");
  property p_ceLead; $fell(flashWeN) |-> $past(!flashCeN); endproperty
  a_ceLead: assert property (p_ceLead)
    else $error("select does not lead strobe");
  property p_noClash; !(!flashOeN && !flashWeN); endproperty
  a_noClash: assert property (p_noClash)
    else $error("read and write strobes together");
  property p_drive; !flashWeN |-> !flashDqOeN; endproperty
  a_drive: assert property (p_drive)
    else $error("data not driven in write");
  property p_noDrive; !flashOeN |-> flashDqOeN; endproperty
  a_noDrive: assert property (p_noDrive)
    else $error("data driven in read");
  property p_hold;
    !flashWeN && $past(!flashWeN) |-> $stable(flashAddr) && $stable(flashDqOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved in write");
  property p_apb; psel && !penable |=> pready; endproperty
  a_apb: assert property (p_apb)
    else $error("no answer after setup");
endmodule
bind fcw_flash_ctrl fcw_flash_ctrl_assertions #(.AW(AW), .DW(DW)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .flashCeN(flashCeN), .flashOeN(flashOeN),
  .flashWeN(flashWeN), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
  .flashDqOeN(flashDqOeN));

// >>> testbench/fcw_flash_model.sv
// Model: flash device answering the controller's command bus
`timescale 1ns/10ps
module fcw_flash_model #(
  parameter logic [8:0] PROT_SEC = 9'h1A5
) (
  // Bus from the controller, and fail switch from the bench
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [20:0] addr,
  input wire logic [15:0] dqOut,
  input wire logic failMode,
  // Back to the controller and bench
  output logic [15:0] dqIn,
  output logic rbLow,
  output int nWr,
  output logic [15:0] lastW
);
  logic [15:0] mem [16];
  logic [20:0] latAddr;
  logic [7:0] prevCmd;
  logic busy, asel, tog, pv, ers;
  int left;
  wire wr = !weN && !ceN;
  wire rd = !oeN && !ceN;
  wire [7:0] d = dqOut[7:0];
  // Open-drain pin pulled low while an operation runs
  assign rbLow = busy;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {busy, asel, tog, pv, ers, prevCmd, nWr, lastW, dqIn, left} = '0;
  end
  // Address at the later falling edge of select or strobe
  always @(posedge wr) latAddr = addr;
  // Data at the earlier rising edge; commands decode from the low data byte
  always @(negedge wr) begin
    nWr++;
    lastW = dqOut;
    if (d == 8'hF0) begin
      busy = 1'b0;
      asel = 1'b0;
    end else if (d == 8'hB0) busy = 1'b0;
    else if (prevCmd == 8'hA0 && !busy) begin
      if (latAddr[20:12] != PROT_SEC) mem[latAddr[3:0]] &= dqOut;
      pv = dqOut[7];
      ers = 1'b0;
      busy = 1'b1;
      left = 3;
    end else if (prevCmd == 8'h55 && (d == 8'h10 || d == 8'h30)) begin
      if (d == 8'h10 || latAddr[20:12] != PROT_SEC)
        foreach (mem[i]) mem[i] = 16'hFFFF;
      pv = 1'b1;
      ers = 1'b1;
      busy = 1'b1;
      left = 3;
    end else asel = (d == 8'h90);
    prevCmd = d;
  end
  // Status while busy: toggle bit inverts on every read
  always @(posedge rd) begin
    if (busy) begin
      tog = !tog;
      dqIn = {8'h00, !pv, tog, failMode, 5'h00};
      dqIn[3:2] = {ers, ers && tog};
      left = failMode ? left : left - 1;
      busy = left > 0;
    end else if (asel) dqIn = {15'h0000, addr[20:12] == PROT_SEC};
    else dqIn = mem[addr[3:0]];
  end
  // A released bus shows the inverse of the last value
  always @(negedge rd) dqIn = ~dqIn;
endmodule

// >>> testbench/tb_fcw_flash_ctrl.sv
// Testbench: APB orders to the controller against a flash model
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module tb_fcw_flash_ctrl import fcw_pkg::*; ;
  typedef struct {
    fcw_op_t o; logic [20:0] a; logic [15:0] w; int n;
    logic [15:0] l; logic [15:0] r; logic c; logic [1:0] s;
  } fcw_row_t;
  localparam logic [8:0] PSEC = 9'h1A5;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic ceN, oeN, weN, dqOeN, rbLow, failMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [20:0] fAddr;
  logic [15:0] dqIn, dqOut, lastW;
  int nWr, errors, checks_done, n0;
  fcw_row_t rows [20];
  // Pull-up resolves the open-drain ready line
  wire ready_busy_n = rbLow ? 1'b0 : 1'b1;
  fcw_flash_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flashCeN(ceN),
    .flashOeN(oeN), .flashWeN(weN), .flashAddr(fAddr), .flashDqIn(dqIn),
    .flashDqOut(dqOut), .flashDqOeN(dqOeN), .ready_busy_n(ready_busy_n));
  fcw_flash_model #(.PROT_SEC(PSEC)) mdl (.ceN(ceN), .oeN(oeN), .weN(weN),
    .addr(fAddr), .dqOut(dqOut), .failMode(failMode), .dqIn(dqIn),
    .rbLow(rbLow), .nWr(nWr), .lastW(lastW));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (k >= 20) begin
      errors++;
      give_verdict();
    end
  endtask
  // Start an operation, wait for done, compare the outcome
  task automatic run(input fcw_row_t x);
    int k;
    n0 = nWr;
    apb(1'b1, REG_ADDR, {11'h000, x.a});
    apb(1'b1, REG_WDATA, {16'h0000, x.w});
    apb(1'b1, REG_CTRL, {28'h0000000, x.o});
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (!(rd[ST_DONE] === 1'b1 && rd[ST_BUSY] === 1'b0) && k < 500);
    if (k >= 500) begin
      errors++;
      give_verdict();
    end
    st = rd;
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK(nWr - n0, x.n)
    `CHK(st[2:1], x.s)
    if (x.n > 0) `CHK(lastW, x.l)
    if (x.c) `CHK(rd[15:0], x.r)
  endtask
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, failMode} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {errors, checks_done} = '0;
    rows = '{
      '{OP_PROGRAM, 21'h3, 16'h1234, 4, 16'h1234, 16'h1234, 1'b1, 2'h0},
      '{OP_READ, 21'h3, 16'h0, 0, 16'h0, 16'h1234, 1'b1, 2'h0},
      '{OP_SECT_ERASE, 21'h3, 16'h0, 6, 16'h0030, 16'h0, 1'b0, 2'h0},
      '{OP_READ, 21'h3, 16'h0, 0, 16'h0, 16'hFFFF, 1'b1, 2'h0},
      '{OP_PROT_VERIFY, {PSEC, 12'h0}, 16'h0, 3, 16'h90, 16'h1, 1'b1, 2'h0},
      '{OP_RESET, 21'h0, 16'h0, 1, 16'h00F0, 16'h0, 1'b0, 2'h0},
      '{OP_PROT_VERIFY, 21'h0, 16'h0, 3, 16'h0090, 16'h0, 1'b1, 2'h0},
      '{OP_RESET, 21'h0, 16'h0, 1, 16'h00F0, 16'h0, 1'b0, 2'h0},
      '{OP_BYP_ENTER, 21'h0, 16'h0, 3, 16'h0020, 16'h0, 1'b0, 2'h2},
      '{OP_PROGRAM, 21'h5, 16'h00A5, 2, 16'h00A5, 16'h00A5, 1'b1, 2'h2},
      '{OP_BYP_EXIT, 21'h0, 16'h0, 2, 16'h0000, 16'h0, 1'b0, 2'h0},
      '{OP_CHIP_ERASE, 21'h0, 16'h0, 6, 16'h0010, 16'h0, 1'b0, 2'h0},
      '{OP_QUERY, 21'h0, 16'h0, 1, 16'h0098, 16'h0, 1'b0, 2'h0},
      '{OP_RESET, 21'h0, 16'h0, 1, 16'h00F0, 16'h0, 1'b0, 2'h0},
      '{OP_TEMP_UNPROT, 21'h0, 16'h0, 3, 16'h0077, 16'h0, 1'b0, 2'h0},
      '{OP_SUSPEND, 21'h3, 16'h0, 1, 16'h00B0, 16'h0, 1'b0, 2'h0},
      '{OP_RESUME, 21'h0, 16'h0, 1, 16'h0030, 16'h0, 1'b0, 2'h0},
      '{OP_PROGRAM, {PSEC, 12'h1}, 16'h0, 4, 16'h0, 16'hFFFF, 1'b1, 2'h0},
      '{OP_PROGRAM, 21'h6, 16'h0F00, 4, 16'h0F00, 16'h0F00, 1'b1, 2'h0},
      '{OP_SECT_ERASE, {PSEC, 12'h6}, 16'h0, 6, 16'h0030, 16'h0F00, 1'b1,
        2'h0}
    };
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd, 32'h00000008)
    foreach (rows[i]) run(rows[i]);
    failMode <= 1'b1;
    run('{OP_PROGRAM, 21'h7, 16'h0F0F, 5, 16'h00F0, 16'h0, 1'b0, 2'h1});
    failMode <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd, 32'h00000008)
    give_verdict();
  end
endmodule
